// ### design/mpg_pkg.sv
// constants, register map and state codes of the move profile generator
package mpg_pkg;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int          CLK_HZ        = 20_000_000;
	localparam int          TICK_TIME_US  = 1000;
	localparam int          TICK_CYC      = CLK_HZ / 1_000_000 * TICK_TIME_US;

	// --------------------------------------------------------------
	// scaling
	// --------------------------------------------------------------
	localparam int          ACC_SCALE     = 1000;
	localparam int          JERK_DIV      = 100;
	localparam logic [15:0] JERK_MAX      = 16'h1388;
	localparam int          RATE_FRAC     = 100_000;
	localparam logic [47:0] STEP_THRESH   = 48'(CLK_HZ) * 48'(RATE_FRAC);

	// --------------------------------------------------------------
	// register offsets
	// --------------------------------------------------------------
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_STATUS    = 8'h04;
	localparam logic [7:0]  OFS_START     = 8'h08;
	localparam logic [7:0]  OFS_TARGET    = 8'h0C;
	localparam logic [7:0]  OFS_ACCEL     = 8'h10;
	localparam logic [7:0]  OFS_DECEL     = 8'h14;
	localparam logic [7:0]  OFS_JERK      = 8'h18;
	localparam logic [7:0]  OFS_LEN       = 8'h1C;
	localparam logic [7:0]  OFS_CUR_RATE  = 8'h20;
	localparam logic [7:0]  OFS_REMAIN    = 8'h24;
	localparam logic [7:0]  OFS_PEAK      = 8'h28;
	localparam logic [7:0]  OFS_UP_TIME   = 8'h2C;
	localparam logic [7:0]  OFS_DN_TIME   = 8'h30;
	localparam logic [7:0]  OFS_UP_STEPS  = 8'h34;
	localparam logic [7:0]  OFS_DN_STEPS  = 8'h38;
	localparam logic [7:0]  OFS_CRUISE    = 8'h3C;
	localparam logic [7:0]  OFS_TOTAL     = 8'h40;

	// --------------------------------------------------------------
	// fields and reset values
	// --------------------------------------------------------------
	localparam int          CTRL_GO_BIT   = 0;
	localparam int          CTRL_ABORT_BIT = 1;
	localparam int          STAT_BUSY_BIT = 0;
	localparam int          STAT_DONE_BIT = 1;
	localparam int          STAT_ST_LSB   = 4;
	localparam logic [23:0] RST_START     = 24'h00008D;
	localparam logic [23:0] RST_TARGET    = 24'h0003E8;
	localparam logic [23:0] RST_ACCEL     = 24'h000014;
	localparam logic [23:0] RST_DECEL     = 24'h000014;
	localparam logic [15:0] RST_JERK      = 16'h0000;
	localparam logic [31:0] RST_LEN       = 32'h00000000;

	// --------------------------------------------------------------
	// motion states
	// --------------------------------------------------------------
	typedef enum logic [3:0]
	{
		ST_IDLE   = 4'b0001,
		ST_ACCEL  = 4'b0010,
		ST_CRUISE = 4'b0100,
		ST_DECEL  = 4'b1000
	} mpg_state_e;

endpackage : mpg_pkg

// ### design/mpg_step_gen.sv
// phase accumulator turning a fractional rate into step pulses
module mpg_step_gen
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        run,
	input  wire logic [47:0] rate_u,
	output logic             step
);

	logic [48:0] phase_q;
	logic [48:0] phase_d;
	logic        step_q;
	logic        step_d;
	logic [48:0] sum;

	// rate stays below the clock, so at most one step per cycle
	always_comb
	begin
		sum     = phase_q + {1'b0, rate_u};
		phase_d = sum;
		step_d  = 1'b0;
		if (!run)
		begin
			phase_d = 49'h0;
		end
		else if (sum >= {1'b0, mpg_pkg::STEP_THRESH})
		begin
			phase_d = sum - {1'b0, mpg_pkg::STEP_THRESH};
			step_d  = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			phase_q <= 49'h0;
			step_q  <= 1'b0;
		end
		else
		begin
			phase_q <= phase_d;
			step_q  <= step_d;
		end
	end

	assign step = step_q;

endmodule : mpg_step_gen

// ### design/mpg_tick.sv
// millisecond tick divider for the profile update
module mpg_tick
#(
	parameter int TICK_CYC = 20000
)
(
	input  wire logic clk,
	input  wire logic rst,
	output logic      tick
);

	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic        tick_q;
	logic        tick_d;

	always_comb
	begin
		tick_d = 1'b0;
		cnt_d  = cnt_q + 32'h1;
		if (cnt_q == 32'(TICK_CYC - 1))
		begin
			cnt_d  = 32'h0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_q  <= 32'h0;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

endmodule : mpg_tick

// ### design/mpg_top.sv
// move profile generator: apb registers, ramp state machine, statistics
//
// Chosen here: the address map and the APB interface to the registers.

// Contract
// - accel/decel given per ms per s, times 1000
// - linear ramp from start toward target rate
// - ramp time and steps follow linear ramp
// - ramps fit: cruise at target between them
// - exact fit: one pulse at target, then decel
// - too short: decel before target, peak recorded
// - cruise steps and total time measured
// - jerk 1 to 5000 gives s-curve ramps
// - jerk equals parameter over 100 times accel
// - jerk parameter kept as sixteen-bit scaled value
// - decel ramps scale jerk by decel value
// - s-curve accel profile triangular or trapezoidal
// - jerk zero selects constant acceleration
module mpg_top
#(
	parameter int TICK_CYC = mpg_pkg::TICK_CYC
)
(
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	output logic             STEP_OUT,
	output logic             BUSY_OUT
);

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic logic [23:0] rate_whole(input logic [47:0] r);
		rate_whole = 24'(r / 48'(mpg_pkg::RATE_FRAC));
	endfunction : rate_whole

	// true once the remaining rate change only covers the jerk-down leg
	function automatic logic jerk_turn(input logic [47:0] a, input logic [47:0] js,
		input logic [47:0] dv);
		jerk_turn = ({16'h0, 96'(a) * 96'(a)} >= (112'(js) * 112'(dv) << 1));
	endfunction : jerk_turn

	// --------------------------------------------------------------
	// declarations
	// --------------------------------------------------------------
	mpg_pkg::mpg_state_e st_q, st_d;
	logic [23:0] start_q, start_d, target_q, target_d;
	logic [23:0] accel_q, accel_d, decel_q, decel_d;
	logic [15:0] jerk_q, jerk_d;
	logic [31:0] len_q, len_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d, pslverr_q, pslverr_d;
	logic        go_q, go_d, abort_q, abort_d, done_q, done_d;
	logic        step_o_q, busy_o_q, cruised_q, cruised_d;
	logic [47:0] rate_q, rate_d, acc_q, acc_d;
	logic [31:0] rem_q, rem_d;
	logic [23:0] peak_q, peak_d;
	logic [31:0] up_t_q, up_t_d, dn_t_q, dn_t_d, tot_q, tot_d;
	logic [31:0] up_s_q, up_s_d, dn_s_q, dn_s_d, cr_s_q, cr_s_d;
	logic        tick, step, run, acc_cyc, hit;
	logic [15:0] jerk_eff;
	logic        scurve;
	logic [47:0] a_lim, d_lim, ja, jd, vs_u, vp_u;
	logic [23:0] rate_i;
	logic [63:0] need, dd2;
	logic        dn_gt, dn_ge;

	// --------------------------------------------------------------
	// submodules
	// --------------------------------------------------------------
	mpg_tick #(.TICK_CYC(TICK_CYC)) u_tick
	(
		.clk  (CLK),
		.rst  (RST),
		.tick (tick)
	);

	mpg_step_gen u_step
	(
		.clk    (CLK),
		.rst    (RST),
		.run    (run),
		.rate_u (rate_q),
		.step   (step)
	);

	// --------------------------------------------------------------
	// derived profile terms
	// --------------------------------------------------------------
	always_comb
	begin
		jerk_eff = (jerk_q > mpg_pkg::JERK_MAX) ? mpg_pkg::JERK_MAX : jerk_q;
		scurve   = (jerk_eff != 16'h0);
		// acc held in 1/100 steps/s^2, rate in 1e-5 steps/s
		a_lim    = 48'(accel_q) * 48'(mpg_pkg::ACC_SCALE * mpg_pkg::JERK_DIV);
		d_lim    = 48'(decel_q) * 48'(mpg_pkg::ACC_SCALE * mpg_pkg::JERK_DIV);
		// per ms: jerk = J/100 * a, in 1/100 steps/s^2 units
		ja       = 48'(jerk_eff) * 48'(accel_q);
		jd       = 48'(jerk_eff) * 48'(decel_q);
		vs_u     = 48'(start_q) * 48'(mpg_pkg::RATE_FRAC);
		vp_u     = 48'(target_q) * 48'(mpg_pkg::RATE_FRAC);
		rate_i   = rate_whole(rate_q);
		// stopping distance: (v^2 - vs^2) / (2d), compared without divide
		need     = 64'(rate_i) * 64'(rate_i) - 64'(start_q) * 64'(start_q);
		dd2      = 64'(decel_q) * 64'(2 * mpg_pkg::ACC_SCALE) * 64'(rem_q);
		dn_gt    = (rate_q >= vs_u) && (need > dd2);
		dn_ge    = (rate_q >= vs_u) && (need >= dd2);
		run      = (st_q != mpg_pkg::ST_IDLE) && (rem_q != 32'h0);
	end

	// --------------------------------------------------------------
	// apb slave and configuration
	// --------------------------------------------------------------
	assign acc_cyc = PSEL && PENABLE && pready_q;

	always_comb
	begin
		start_d   = start_q;
		target_d  = target_q;
		accel_d   = accel_q;
		decel_d   = decel_q;
		jerk_d    = jerk_q;
		len_d     = len_q;
		go_d      = 1'b0;
		abort_d   = 1'b0;
		prdata_d  = 32'h0;
		pslverr_d = 1'b0;
		hit       = 1'b1;
		// one wait state: answer on the second access cycle
		pready_d  = PSEL && PENABLE && !pready_q;
		case (PADDR)
			mpg_pkg::OFS_CTRL:     prdata_d = 32'h0;
			mpg_pkg::OFS_STATUS:   prdata_d = {24'h0, st_q, 2'b00, done_q, busy_o_q};
			mpg_pkg::OFS_START:    prdata_d = {8'h0, start_q};
			mpg_pkg::OFS_TARGET:   prdata_d = {8'h0, target_q};
			mpg_pkg::OFS_ACCEL:    prdata_d = {8'h0, accel_q};
			mpg_pkg::OFS_DECEL:    prdata_d = {8'h0, decel_q};
			mpg_pkg::OFS_JERK:     prdata_d = {16'h0, jerk_q};
			mpg_pkg::OFS_LEN:      prdata_d = len_q;
			mpg_pkg::OFS_CUR_RATE: prdata_d = {8'h0, rate_i};
			mpg_pkg::OFS_REMAIN:   prdata_d = rem_q;
			mpg_pkg::OFS_PEAK:     prdata_d = {8'h0, peak_q};
			mpg_pkg::OFS_UP_TIME:  prdata_d = up_t_q;
			mpg_pkg::OFS_DN_TIME:  prdata_d = dn_t_q;
			mpg_pkg::OFS_UP_STEPS: prdata_d = up_s_q;
			mpg_pkg::OFS_DN_STEPS: prdata_d = dn_s_q;
			mpg_pkg::OFS_CRUISE:   prdata_d = cr_s_q;
			mpg_pkg::OFS_TOTAL:    prdata_d = tot_q;
			default:               hit = 1'b0;
		endcase
		if (!pready_d)
		begin
			prdata_d = 32'h0;
		end
		if (pready_d && (!hit || PADDR[1:0] != 2'b00))
		begin
			pslverr_d = 1'b1;
			prdata_d  = 32'h0;
		end
		if (!PWRITE)
		begin
		end
		else
		begin
			prdata_d = 32'h0;
		end
		// profile parameters are frozen while a move runs
		if (acc_cyc && PWRITE && !pslverr_q)
		begin
			if (PADDR == mpg_pkg::OFS_CTRL)
			begin
				go_d    = PWDATA[mpg_pkg::CTRL_GO_BIT];
				abort_d = PWDATA[mpg_pkg::CTRL_ABORT_BIT];
			end
			else if (st_q == mpg_pkg::ST_IDLE)
			begin
				case (PADDR)
					mpg_pkg::OFS_START:  start_d  = PWDATA[23:0];
					mpg_pkg::OFS_TARGET: target_d = PWDATA[23:0];
					mpg_pkg::OFS_ACCEL:  accel_d  = PWDATA[23:0];
					mpg_pkg::OFS_DECEL:  decel_d  = PWDATA[23:0];
					mpg_pkg::OFS_JERK:   jerk_d   = PWDATA[15:0];
					mpg_pkg::OFS_LEN:    len_d    = PWDATA;
					default:             len_d    = len_q;
				endcase
			end
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			start_q   <= mpg_pkg::RST_START;
			target_q  <= mpg_pkg::RST_TARGET;
			accel_q   <= mpg_pkg::RST_ACCEL;
			decel_q   <= mpg_pkg::RST_DECEL;
			jerk_q    <= mpg_pkg::RST_JERK;
			len_q     <= mpg_pkg::RST_LEN;
			go_q      <= 1'b0;
			abort_q   <= 1'b0;
			prdata_q  <= 32'h0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			start_q   <= start_d;
			target_q  <= target_d;
			accel_q   <= accel_d;
			decel_q   <= decel_d;
			jerk_q    <= jerk_d;
			len_q     <= len_d;
			go_q      <= go_d;
			abort_q   <= abort_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// --------------------------------------------------------------
	// ramp state machine
	// --------------------------------------------------------------
	always_comb
	begin
		st_d      = st_q;
		rate_d    = rate_q;
		acc_d     = acc_q;
		rem_d     = rem_q;
		done_d    = done_q;
		cruised_d = cruised_q;
		if (step && rem_q != 32'h0)
		begin
			rem_d = rem_q - 32'h1;
		end
		case (st_q)
			mpg_pkg::ST_IDLE:
			begin
				rem_d = rem_q;
				if (go_q && len_q != 32'h0)
				begin
					done_d    = 1'b0;
					rem_d     = len_q;
					rate_d    = vs_u;
					acc_d     = scurve ? 48'h0 : a_lim;
					cruised_d = 1'b0;
					st_d      = (start_q >= target_q) ? mpg_pkg::ST_CRUISE : mpg_pkg::ST_ACCEL;
				end
			end
			mpg_pkg::ST_ACCEL:
			begin
				if (dn_gt)
				begin
					acc_d = scurve ? 48'h0 : d_lim;
					st_d  = mpg_pkg::ST_DECEL;
				end
				else if (tick)
				begin
					if (scurve && jerk_turn(acc_q, ja, vp_u - rate_q))
					begin
						acc_d = (acc_q > ja) ? acc_q - ja : ja;
					end
					else if (scurve)
					begin
						acc_d = (acc_q + ja > a_lim) ? a_lim : acc_q + ja;
					end
					if (rate_q + acc_q >= vp_u)
					begin
						rate_d    = vp_u;
						cruised_d = 1'b0;
						st_d      = mpg_pkg::ST_CRUISE;
					end
					else
					begin
						rate_d = rate_q + acc_q;
					end
				end
			end
			mpg_pkg::ST_CRUISE:
			begin
				if (step)
				begin
					cruised_d = 1'b1;
				end
				// at least one pulse at target rate before the down ramp
				if (cruised_q && dn_ge)
				begin
					acc_d = scurve ? 48'h0 : d_lim;
					st_d  = mpg_pkg::ST_DECEL;
				end
			end
			mpg_pkg::ST_DECEL:
			begin
				if (tick)
				begin
					if (scurve && jerk_turn(acc_q, jd, rate_q - vs_u))
					begin
						acc_d = (acc_q > jd) ? acc_q - jd : jd;
					end
					else if (scurve)
					begin
						acc_d = (acc_q + jd > d_lim) ? d_lim : acc_q + jd;
					end
					// floor at start rate; finish remaining steps there
					rate_d = (rate_q > vs_u + acc_q) ? rate_q - acc_q : vs_u;
				end
			end
			default:
			begin
				st_d = mpg_pkg::ST_IDLE;
			end
		endcase
		if (st_q != mpg_pkg::ST_IDLE && (abort_q || rem_q == 32'h0))
		begin
			st_d   = mpg_pkg::ST_IDLE;
			rate_d = 48'h0;
			acc_d  = 48'h0;
			rem_d  = 32'h0;
			done_d = 1'b1;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			st_q      <= mpg_pkg::ST_IDLE;
			rate_q    <= 48'h0;
			acc_q     <= 48'h0;
			rem_q     <= 32'h0;
			done_q    <= 1'b0;
			cruised_q <= 1'b0;
			step_o_q  <= 1'b0;
			busy_o_q  <= 1'b0;
		end
		else
		begin
			st_q      <= st_d;
			rate_q    <= rate_d;
			acc_q     <= acc_d;
			rem_q     <= rem_d;
			done_q    <= done_d;
			cruised_q <= cruised_d;
			// no pulse on the abort edge: busy already falls there
			step_o_q  <= step && run && (st_d != mpg_pkg::ST_IDLE);
			busy_o_q  <= (st_d != mpg_pkg::ST_IDLE);
		end
	end

	// --------------------------------------------------------------
	// move statistics
	// --------------------------------------------------------------
	always_comb
	begin
		peak_d = peak_q;
		up_t_d = up_t_q;
		dn_t_d = dn_t_q;
		tot_d  = tot_q;
		up_s_d = up_s_q;
		dn_s_d = dn_s_q;
		cr_s_d = cr_s_q;
		if (st_q == mpg_pkg::ST_IDLE && go_q && len_q != 32'h0)
		begin
			peak_d = start_q;
			up_t_d = 32'h0;
			dn_t_d = 32'h0;
			tot_d  = 32'h0;
			up_s_d = 32'h0;
			dn_s_d = 32'h0;
			cr_s_d = 32'h0;
		end
		else if (run)
		begin
			if (rate_i > peak_q)
			begin
				peak_d = rate_i;
			end
			if (tick)
			begin
				tot_d = tot_q + 32'h1;
			end
			if (tick && st_q == mpg_pkg::ST_ACCEL)
			begin
				up_t_d = up_t_q + 32'h1;
			end
			if (tick && st_q == mpg_pkg::ST_DECEL)
			begin
				dn_t_d = dn_t_q + 32'h1;
			end
			if (step && st_q == mpg_pkg::ST_ACCEL)
			begin
				up_s_d = up_s_q + 32'h1;
			end
			if (step && st_q == mpg_pkg::ST_DECEL)
			begin
				dn_s_d = dn_s_q + 32'h1;
			end
			if (step && st_q == mpg_pkg::ST_CRUISE)
			begin
				cr_s_d = cr_s_q + 32'h1;
			end
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			peak_q <= 24'h0;
			up_t_q <= 32'h0;
			dn_t_q <= 32'h0;
			tot_q  <= 32'h0;
			up_s_q <= 32'h0;
			dn_s_q <= 32'h0;
			cr_s_q <= 32'h0;
		end
		else
		begin
			peak_q <= peak_d;
			up_t_q <= up_t_d;
			dn_t_q <= dn_t_d;
			tot_q  <= tot_d;
			up_s_q <= up_s_d;
			dn_s_q <= dn_s_d;
			cr_s_q <= cr_s_d;
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign PRDATA   = prdata_q;
	assign PREADY   = pready_q;
	assign PSLVERR  = pslverr_q;
	assign STEP_OUT = step_o_q;
	assign BUSY_OUT = busy_o_q;

endmodule : mpg_top

// ### tb/mpg_checker.sv
// port assertions of the move profile generator
module mpg_checker
(
	input wire logic        CLK,
	input wire logic        RST,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        STEP_OUT,
	input wire logic        BUSY_OUT
);
	// ------------------------------------------------------------
	// bus and step relations
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	logic acc;
	assign acc = PSEL && PENABLE && PREADY;

	AST_APB_WAIT: assert property ((PSEL && !PENABLE) |=> !PREADY ##1 PREADY)
		else $error("ready not after exactly one wait state");
	AST_READY_PULSE: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	AST_READY_ACCESS: assert property (PREADY |-> PSEL && PENABLE)
		else $error("ready outside an access phase");
	AST_ERR_UNALIGNED: assert property (acc && PADDR[1:0] != 2'h0 |-> PSLVERR && PRDATA == 32'h0)
		else $error("unaligned access not refused");
	AST_ERR_ONLY_READY: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	AST_RDATA_IDLE: assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("read data outside ready cycle");
	AST_STEP_PULSE: assert property (STEP_OUT |=> !STEP_OUT)
		else $error("step pulse wider than one cycle");
	AST_STEP_IN_MOVE: assert property (STEP_OUT |-> BUSY_OUT)
		else $error("step outside a move");
	AST_IDLE_QUIET: assert property (!BUSY_OUT && !$past(BUSY_OUT) |-> !STEP_OUT)
		else $error("step while idle");
	AST_ABORT_STOP: assert property (acc && PWRITE && PADDR == 8'h00 && PWDATA[1] |-> ##[1:3] !BUSY_OUT)
		else $error("abort did not stop the move");
	AST_RESET_QUIET: assert property ($fell(RST) |-> !BUSY_OUT && !STEP_OUT && !PREADY)
		else $error("outputs active right after reset");

	COV_STEP: cover property (STEP_OUT);
	COV_ERR: cover property (PSLVERR);
	COV_END: cover property ($fell(BUSY_OUT));
endmodule : mpg_checker

bind mpg_top mpg_checker i_chk
(
	.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .STEP_OUT(STEP_OUT),
	.BUSY_OUT(BUSY_OUT)
);

// ### tb/mpg_stage_model.sv
// step pulse counter standing in for the motor power stage
module mpg_stage_model
(
	input  wire logic        clk,
	input  wire logic        clr,
	input  wire logic        step,
	output logic      [31:0] n_steps,
	output logic      [31:0] min_gap
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] gap;

	// ------------------------------------------------------------
	// pulse count and tightest spacing, the stage's speed limit
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		if (clr)
		begin
			n_steps <= 32'h0;
			min_gap <= 32'hFFFFFFFF;
			gap     <= 32'h0;
		end
		else if (step)
		begin
			n_steps <= n_steps + 32'h1;
			gap     <= 32'h1;
			if (n_steps != 32'h0 && gap < min_gap)
				min_gap <= gap;
		end
		else
			gap <= gap + 32'h1;
	end
endmodule : mpg_stage_model

// ### tb/tb_mpg_top.sv
// self-checking testbench of the move profile generator
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_errors++; \
	$display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb_mpg_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// profile settings, short tick keeps runs brief
	// ------------------------------------------------------------
	localparam logic [31:0] V_S = 32'h000186A0;
	localparam logic [31:0] V_P = 32'h000F4240;
	localparam logic [31:0] DEC = 32'h00F42400;
	localparam longint STOP_D = (longint'(V_P) * V_P - longint'(V_S) * V_S) / (2 * mpg_pkg::ACC_SCALE * longint'(DEC));
	logic        CLK;
	logic        RST;
	logic        PSEL;
	logic        PENABLE;
	logic        PWRITE;
	logic [7:0]  PADDR;
	logic [31:0] PWDATA;
	logic [31:0] PRDATA;
	logic        PREADY;
	logic        PSLVERR;
	logic        STEP_OUT;
	logic        BUSY_OUT;
	logic        clr;
	logic        err;
	logic [31:0] rd;
	logic [31:0] n_steps;
	logic [31:0] min_gap;
	logic [31:0] up_lin;
	int          n_errors;
	int          total_checks;

	mpg_top #(.TICK_CYC(20)) i_dut
	(
		.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .STEP_OUT(STEP_OUT),
		.BUSY_OUT(BUSY_OUT)
	);
	mpg_stage_model i_stage
	(
		.clk(CLK), .clr(clr), .step(STEP_OUT), .n_steps(n_steps), .min_gap(min_gap)
	);

	initial
	begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end

	// ------------------------------------------------------------
	// bus and move helpers
	// ------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		PSEL    <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE  <= wr;
		PADDR   <= a;
		PWDATA  <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		n = 0;
		do
		begin
			@(posedge CLK);
			n++;
		end
		while (PREADY !== 1'b1 && n < 50);
		if (PREADY !== 1'b1)
		begin
			n_errors++;
			summarize();
		end
		rd  = PRDATA;
		err = PSLVERR;
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask : apb

	task automatic wait_idle();
		int n;
		for (n = 0; n < 40000 && BUSY_OUT !== 1'b0; n++)
			@(posedge CLK);
		if (BUSY_OUT !== 1'b0)
		begin
			n_errors++;
			summarize();
		end
	endtask : wait_idle

	// a start that is refused leaves busy low through the bounded wait
	task automatic move(input logic [31:0] len, input logic [15:0] jerk);
		int n;
		apb(1'b1, mpg_pkg::OFS_LEN, len);
		apb(1'b1, mpg_pkg::OFS_JERK, {16'h0000, jerk});
		clr <= 1'b1;
		@(posedge CLK);
		clr <= 1'b0;
		apb(1'b1, mpg_pkg::OFS_CTRL, 32'h00000001);
		for (n = 0; n < 10 && BUSY_OUT !== 1'b1; n++)
			@(posedge CLK);
	endtask : move

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		logic [7:0]  ofs [6] = '{mpg_pkg::OFS_START, mpg_pkg::OFS_TARGET, mpg_pkg::OFS_ACCEL,
			mpg_pkg::OFS_DECEL, mpg_pkg::OFS_JERK, mpg_pkg::OFS_LEN};
		logic [31:0] ex [6] = '{32'(mpg_pkg::RST_START), 32'(mpg_pkg::RST_TARGET), 32'(mpg_pkg::RST_ACCEL),
			32'(mpg_pkg::RST_DECEL), 32'(mpg_pkg::RST_JERK), mpg_pkg::RST_LEN};
		foreach (ofs[i])
		begin
			apb(1'b0, ofs[i], 32'h0);
			`CHK("reset value", ex[i], rd)
		end
		apb(1'b0, 8'h44, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0, rd)
		apb(1'b1, 8'h1A, 32'h0);
		`CHK("unaligned err", 1'b1, err)
		apb(1'b1, mpg_pkg::OFS_JERK, 32'hFFFF0010);
		apb(1'b0, mpg_pkg::OFS_JERK, 32'h0);
		`CHK("jerk width", 32'h00000010, rd)
		$display("test regs done");
	endtask : t_regs

	task automatic t_trap();
		int          n;
		logic [31:0] dn;
		logic [31:0] cr;
		logic [31:0] td;
		move(32'h00000050, 16'h0000);
		for (n = 0; n < 500 && rd[7:4] !== 4'h4; n++)
			apb(1'b0, mpg_pkg::OFS_STATUS, 32'h0);
		`CHK("cruise state", 4'h4, rd[7:4])
		apb(1'b1, mpg_pkg::OFS_CTRL, 32'h00000001);
		apb(1'b1, mpg_pkg::OFS_TARGET, 32'h00000100);
		wait_idle();
		`CHK("steps", 32'h00000050, n_steps)
		`CHK("gap", 1'b1, min_gap >= 32'h14)
		apb(1'b0, mpg_pkg::OFS_TARGET, 32'h0);
		`CHK("target kept", V_P, rd)
		apb(1'b0, mpg_pkg::OFS_PEAK, 32'h0);
		`CHK("peak", V_P, rd)
		apb(1'b0, mpg_pkg::OFS_UP_TIME, 32'h0);
		up_lin = rd;
		`CHK("up time", 1'b1, up_lin inside {[32'h9:32'hB]})
		apb(1'b0, mpg_pkg::OFS_DN_STEPS, 32'h0);
		dn = rd;
		`CHK("down steps", 1'b1, longint'(dn) inside {[STOP_D:STOP_D + 1]})
		apb(1'b0, mpg_pkg::OFS_UP_STEPS, 32'h0);
		cr = 32'h00000050 - rd - dn;
		apb(1'b0, mpg_pkg::OFS_CRUISE, 32'h0);
		`CHK("cruise", cr, rd)
		`CHK("cruise pulse", 1'b1, rd >= 32'h1)
		apb(1'b0, mpg_pkg::OFS_DN_TIME, 32'h0);
		td = rd + up_lin + cr;
		apb(1'b0, mpg_pkg::OFS_TOTAL, 32'h0);
		`CHK("total time", 1'b1, rd + 32'h2 >= td && rd <= td + 32'h2)
		apb(1'b0, mpg_pkg::OFS_STATUS, 32'h0);
		`CHK("status end", 32'h00000012, rd)
		$display("test trapezoid done");
	endtask : t_trap

	task automatic t_short();
		logic [31:0] up;
		move(32'h00000014, 16'h0000);
		wait_idle();
		`CHK("short steps", 32'h00000014, n_steps)
		apb(1'b0, mpg_pkg::OFS_PEAK, 32'h0);
		`CHK("short peak", 1'b1, rd > V_S && rd < V_P)
		apb(1'b0, mpg_pkg::OFS_CRUISE, 32'h0);
		`CHK("short cruise", 32'h0, rd)
		apb(1'b0, mpg_pkg::OFS_UP_STEPS, 32'h0);
		up = rd;
		apb(1'b0, mpg_pkg::OFS_DN_STEPS, 32'h0);
		`CHK("short ramps", 32'h00000014, up + rd)
		$display("test short done");
	endtask : t_short

	task automatic t_scurve();
		logic [31:0] up_s;
		move(32'h00000050, 16'h1388);
		wait_idle();
		`CHK("s steps", 32'h00000050, n_steps)
		apb(1'b0, mpg_pkg::OFS_UP_TIME, 32'h0);
		up_s = rd;
		`CHK("s longer", 1'b1, up_s > up_lin + 32'h5)
		move(32'h00000050, 16'h1770);
		wait_idle();
		apb(1'b0, mpg_pkg::OFS_UP_TIME, 32'h0);
		`CHK("jerk clamp", 1'b1, rd + 32'h1 >= up_s && rd <= up_s + 32'h1)
		$display("test s-curve done");
	endtask : t_scurve

	task automatic t_refuse();
		int n;
		move(32'h00000000, 16'h0000);
		`CHK("zero length go", 1'b0, BUSY_OUT)
		move(32'h000003E8, 16'h0000);
		for (n = 0; n < 4000 && n_steps < 32'h5; n++)
			@(posedge CLK);
		apb(1'b1, mpg_pkg::OFS_CTRL, 32'h00000002);
		wait_idle();
		`CHK("abort", 1'b1, n_steps >= 32'h5 && n_steps < 32'h000003E8)
		$display("test refuse done");
	endtask : t_refuse

	initial
	begin
		RST          = 1'b1;
		PSEL         = 1'b0;
		PENABLE      = 1'b0;
		PWRITE       = 1'b0;
		PADDR        = 8'h00;
		PWDATA       = 32'h0;
		clr          = 1'b1;
		rd           = 32'h0;
		err          = 1'b0;
		n_errors     = 0;
		total_checks = 0;
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		t_regs();
		apb(1'b1, mpg_pkg::OFS_START, V_S);
		apb(1'b1, mpg_pkg::OFS_TARGET, V_P);
		apb(1'b1, mpg_pkg::OFS_ACCEL, 32'h00015F90);
		apb(1'b1, mpg_pkg::OFS_DECEL, DEC);
		t_trap();
		t_short();
		t_scurve();
		t_refuse();
		summarize();
	end
endmodule : tb_mpg_top
